// ---- i2cms_consts.svh ----
`ifndef I2CMS_CONSTS_SVH
`define I2CMS_CONSTS_SVH

// Internal byte address width and the highest location
`define I2CMS_ADDR_W 10
`define I2CMS_TOP_ADDR 10'h03FF

// Slave address byte field positions
`define I2CMS_TYPE_HI 7
`define I2CMS_TYPE_LO 4
`define I2CMS_SEL_BIT 3
`define I2CMS_PAGE_HI 2
`define I2CMS_PAGE_LO 1
`define I2CMS_RW_BIT 0

// Device type code; the value is arbitrary
`define I2CMS_TYPE_CODE 4'h5

// Index of the last bit of a byte
`define I2CMS_LAST_BIT 3'h7

// Power-up delay the master waits before its first start, in us
`define I2CMS_POWER_UP_READ_DELAY_US 1

`endif

// ---- i2cms_pkg.sv ----
package i2cms_pkg;

    // Link engine states
    typedef enum logic [2:0] {
        I2CMS_IDLE = 3'b000,
        I2CMS_ADDR = 3'b001,
        I2CMS_ACK_A = 3'b010,
        I2CMS_WADDR = 3'b011,
        I2CMS_ACK_W = 3'b100,
        I2CMS_WDATA = 3'b101,
        I2CMS_RD = 3'b110,
        I2CMS_RACK = 3'b111
    } i2cms_state_e;

    // Memory write port
    typedef struct packed {
        logic we;
        logic [9:0] waddr;
        logic [7:0] wdata;
    } i2cms_wr_s;

    // System clock domain state
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic scl_d;
        logic sda_d;
        logic lowv_s1;
        logic lowv_s2;
        logic busy;
        logic inhibit;
    } i2cms_sys_s;

    // Link clock domain state
    typedef struct packed {
        logic abort_s1;
        logic abort_s2;
        i2cms_state_e state;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic rw;
        logic [1:0] page;
        logic [9:0] addr;
        logic oe;
        i2cms_wr_s wr;
    } i2cms_link_s;

endpackage

// ---- i2cms_top.sv ----
`timescale 1ns/10ps
`include "i2cms_consts.svh"
module i2cms_top
    import i2cms_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic LOW_VCC,
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    output logic [9:0] MEM_ADDR,
    input wire logic [7:0] MEM_RDATA,
    output i2cms_wr_s MEM_WR,
    output logic LINK_BUSY,
    output logic ACCESS_INHIBIT
);

    // Idle bus levels, inhibit held during reset
    localparam i2cms_sys_s SYS_RESET = '{
        scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
        scl_d: 1'b1, sda_d: 1'b1, lowv_s1: 1'b0, lowv_s2: 1'b0,
        busy: 1'b0, inhibit: 1'b1
    };

    // Saturating address step
    function automatic logic [9:0] addr_step(input logic [9:0] a);
        if (a == `I2CMS_TOP_ADDR) begin
            addr_step = a;
        end else begin
            addr_step = 10'(a + 10'h0001);
        end
    endfunction

    // Type code compare on a received slave byte
    function automatic logic type_match(input logic [7:0] b);
        type_match = (b[`I2CMS_TYPE_HI:`I2CMS_TYPE_LO] == `I2CMS_TYPE_CODE);
    endfunction

    // System domain state
    i2cms_sys_s sys_reg;
    i2cms_sys_s sys_next;
    // Link domain state, falling SCL
    i2cms_link_s link_reg;
    i2cms_link_s link_next;
    // SDA sampled at rising SCL
    logic sda_p_reg;
    // Start and stop seen in last SCL high phase
    logic start_l;
    logic stop_l;
    logic clean_l;
    // Byte with the bit just sampled shifted in
    logic [7:0] shifted;
    // Last bit of a byte this edge
    logic last_bit;
    // Link state after an abort
    i2cms_link_s link_idle;

    // Sync SCL, SDA and low supply; track bus activity
    always_comb begin
        sys_next = sys_reg;
        sys_next.scl_s1 = SCL;
        sys_next.scl_s2 = sys_reg.scl_s1;
        sys_next.sda_s1 = SDA_I;
        sys_next.sda_s2 = sys_reg.sda_s1;
        sys_next.scl_d = sys_reg.scl_s2;
        sys_next.sda_d = sys_reg.sda_s2;
        sys_next.lowv_s1 = LOW_VCC;
        sys_next.lowv_s2 = sys_reg.lowv_s1;
        // Low supply blocks every access
        sys_next.inhibit = sys_reg.lowv_s2;
        if (sys_reg.inhibit) begin
            // Nothing in progress while inhibited
            sys_next.busy = 1'b0;
        end else if (sys_reg.scl_d && sys_reg.scl_s2 && sys_reg.sda_d && !sys_reg.sda_s2) begin
            // Start seen in synchronised samples
            sys_next.busy = 1'b1;
        end else if (sys_reg.scl_d && sys_reg.scl_s2 && !sys_reg.sda_d && sys_reg.sda_s2) begin
            // Stop seen in synchronised samples
            sys_next.busy = 1'b0;
        end
    end

    // System domain register
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sys_reg <= SYS_RESET;
        end else begin
            sys_reg <= sys_next;
        end
    end

    // SDA data sample while SCL is high
    always_ff @(posedge SCL) begin
        sda_p_reg <= SDA_I;
    end

    // Conditions seen at the falling SCL edge
    always_comb begin
        start_l = sda_p_reg && !SDA_I;
        stop_l = !sda_p_reg && SDA_I;
        clean_l = !start_l && !stop_l;
        shifted = {link_reg.shift[6:0], sda_p_reg};
        last_bit = (link_reg.cnt == `I2CMS_LAST_BIT);
        link_idle = link_reg;
        link_idle.state = I2CMS_IDLE;
        link_idle.cnt = 3'h0;
        link_idle.oe = 1'b0;
        link_idle.wr.we = 1'b0;
    end

    // Link engine, one step per falling SCL
    always_comb begin
        link_next = link_reg;
        link_next.abort_s1 = sys_reg.inhibit;
        link_next.abort_s2 = link_reg.abort_s1;
        link_next.wr.we = 1'b0;
        if (start_l) begin
            // New slave address follows
            link_next.state = I2CMS_ADDR;
            link_next.cnt = 3'h0;
            link_next.oe = 1'b0;
        end else if (stop_l || link_reg.abort_s2) begin
            // Stop or low supply ends everything
            link_next = link_idle;
            link_next.abort_s1 = sys_reg.inhibit;
            link_next.abort_s2 = link_reg.abort_s1;
        end else begin
            case (link_reg.state)
                I2CMS_IDLE: begin
                    // Wait for a start
                    link_next.cnt = 3'h0;
                end
                I2CMS_ADDR: begin
                    // Slave address bits
                    link_next.shift = shifted;
                    link_next.cnt = 3'(link_reg.cnt + 3'h1);
                    if (last_bit) begin
                        if (type_match(shifted)) begin
                            // Select bit left unchecked
                            link_next.rw = shifted[`I2CMS_RW_BIT];
                            link_next.page = shifted[`I2CMS_PAGE_HI:`I2CMS_PAGE_LO];
                            link_next.oe = 1'b1;
                            link_next.state = I2CMS_ACK_A;
                            if (shifted[`I2CMS_RW_BIT]) begin
                                // Read keeps low byte of latch
                                link_next.addr[9:8] = shifted[2:1];
                            end
                        end else begin
                            link_next.state = I2CMS_IDLE;
                        end
                    end
                end
                I2CMS_ACK_A: begin
                    // End of address acknowledge
                    link_next.oe = 1'b0;
                    link_next.cnt = 3'h0;
                    if (link_reg.rw) begin
                        // Drive bit 7 of the first byte at once
                        link_next.shift = MEM_RDATA;
                        link_next.oe = !MEM_RDATA[7];
                        link_next.addr = addr_step(link_reg.addr);
                        link_next.state = I2CMS_RD;
                    end else begin
                        link_next.state = I2CMS_WADDR;
                    end
                end
                I2CMS_WADDR: begin
                    // Word address bits
                    link_next.shift = shifted;
                    link_next.cnt = 3'(link_reg.cnt + 3'h1);
                    if (last_bit) begin
                        link_next.addr = {link_reg.page, shifted};
                        link_next.oe = 1'b1;
                        link_next.state = I2CMS_ACK_W;
                    end
                end
                I2CMS_ACK_W: begin
                    // End of our acknowledge, next data byte
                    link_next.oe = 1'b0;
                    link_next.cnt = 3'h0;
                    link_next.state = I2CMS_WDATA;
                end
                I2CMS_WDATA: begin
                    // Write data bits, stored on the eighth
                    link_next.shift = shifted;
                    link_next.cnt = 3'(link_reg.cnt + 3'h1);
                    if (last_bit) begin
                        link_next.wr.we = 1'b1;
                        link_next.wr.wdata = shifted;
                        link_next.wr.waddr = link_reg.addr;
                        link_next.addr = addr_step(link_reg.addr);
                        link_next.oe = 1'b1;
                        link_next.state = I2CMS_ACK_W;
                    end
                end
                I2CMS_RD: begin
                    // Read data bits, released for the master ack
                    if (last_bit) begin
                        link_next.oe = 1'b0;
                        link_next.state = I2CMS_RACK;
                    end else begin
                        link_next.shift = {link_reg.shift[6:0], 1'b0};
                        link_next.oe = !link_reg.shift[6];
                        link_next.cnt = 3'(link_reg.cnt + 3'h1);
                    end
                end
                I2CMS_RACK: begin
                    // Master acknowledge slot
                    if (!sda_p_reg) begin
                        link_next.shift = MEM_RDATA;
                        link_next.oe = !MEM_RDATA[7];
                        link_next.addr = addr_step(link_reg.addr);
                        link_next.cnt = 3'h0;
                        link_next.state = I2CMS_RD;
                    end else begin
                        link_next.state = I2CMS_IDLE;
                    end
                end
                default: begin
                    link_next = link_idle;
                    // Keep the supply abort sync running
                    link_next.abort_s1 = sys_reg.inhibit;
                    link_next.abort_s2 = link_reg.abort_s1;
                end
            endcase
        end
    end

    // Link domain register
    always_ff @(negedge SCL) begin
        link_reg <= link_next;
    end

    // Open-drain output, released while inhibited
    always_comb begin
        SDA_O = 1'b0;
        SDA_OE = link_reg.oe && !sys_reg.inhibit;
        MEM_ADDR = link_reg.addr;
        MEM_WR = link_reg.wr;
        MEM_WR.we = link_reg.wr.we && !sys_reg.inhibit;
        LINK_BUSY = sys_reg.busy;
        ACCESS_INHIBIT = sys_reg.inhibit;
    end

    // Mismatched type code gets no acknowledge
    type_reject_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        (link_reg.state == I2CMS_ADDR && last_bit && clean_l && !type_match(shifted))
        |=> (!link_reg.oe && link_reg.state == I2CMS_IDLE))
        else $error("type mismatch acknowledged");

    // Match acknowledged whatever the select bit
    select_ignore_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        (link_reg.state == I2CMS_ADDR && last_bit && clean_l && type_match(shifted))
        |=> (link_reg.oe && link_reg.state == I2CMS_ACK_A))
        else $error("matching address not acknowledged");

    // Read address sets the page bits
    read_page_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        (link_reg.state == I2CMS_ADDR && last_bit && clean_l && type_match(shifted)
         && shifted[0])
        |=> (link_reg.addr[9:8] == $past(shifted[2:1])
             && link_reg.addr[7:0] == $past(link_reg.addr[7:0])))
        else $error("read page not loaded");

    // Write direction goes to word address
    write_dir_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        (link_reg.state == I2CMS_ACK_A && !link_reg.rw && clean_l)
        |=> (link_reg.state == I2CMS_WADDR && !link_reg.oe))
        else $error("write did not expect word address");

    // Word address joins page bits
    word_load_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        (link_reg.state == I2CMS_WADDR && last_bit && clean_l)
        |=> (link_reg.addr == {$past(link_reg.page), $past(shifted)}) ##1 !link_reg.oe)
        else $error("word address not latched");

    // Write stores and acknowledges for one slot
    write_ack_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        (link_reg.state == I2CMS_WDATA && last_bit && clean_l)
        |=> (link_reg.oe && link_reg.wr.we && link_reg.wr.wdata == $past(shifted))
        ##1 (!link_reg.wr.we))
        else $error("write byte not stored or acknowledged");

    // Address steps once, stops at the top
    addr_step_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        (link_reg.state == I2CMS_WDATA && last_bit && clean_l)
        |=> (link_reg.addr == (($past(link_reg.addr) == `I2CMS_TOP_ADDR) ?
             `I2CMS_TOP_ADDR : 10'($past(link_reg.addr) + 10'h0001))))
        else $error("address latch step wrong");

    // Start resets to address decoding
    start_abort_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        start_l |=> (link_reg.state == I2CMS_ADDR && link_reg.cnt == 3'h0 && !link_reg.oe))
        else $error("start did not restart decoding");

    // Stop returns to idle
    stop_idle_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        stop_l |=> (link_reg.state == I2CMS_IDLE && !link_reg.oe))
        else $error("stop did not idle");

    // Missing master ack ends the read
    read_nack_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        (link_reg.state == I2CMS_RACK && sda_p_reg && clean_l)
        |=> (link_reg.state == I2CMS_IDLE && !link_reg.oe))
        else $error("read continued after no acknowledge");

    // First read bit driven right after the ack
    read_first_a: assert property (
        @(negedge SCL) disable iff (link_reg.abort_s2)
        (link_reg.state == I2CMS_ACK_A && link_reg.rw && clean_l)
        |=> (link_reg.state == I2CMS_RD && link_reg.oe == !$past(MEM_RDATA[7])))
        else $error("read data not driven");

    // Low supply abort leaves the link idle
    supply_abort_a: assert property (
        @(negedge SCL)
        (link_reg.abort_s2 && !start_l)
        |=> (link_reg.state == I2CMS_IDLE && !link_reg.oe && !link_reg.wr.we))
        else $error("low supply did not abort the link");

    // Inhibit releases the line at once
    inhibit_release_a: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        ACCESS_INHIBIT |-> (!SDA_OE && !MEM_WR.we))
        else $error("access while inhibited");

endmodule

// ---- i2cms_master_model.sv ----
`timescale 1ns/10ps
// Bus master model: owns SCL, pulls SDA low; the line has a pull-up
module i2cms_master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    localparam int HALF = 32; // Half of the 64 ns link period
    // Bus idle, clock high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One clock: data set just after the fall, line read mid-high
    task automatic bit_io(input logic b, output logic rb);
        #4 sda_low = !b;
        #(HALF - 4);
        scl = 1'b1;
        #16 rb = sda;
        #16 scl = 1'b0;
    endtask
    // Clocks with SDA released, to flush the link after a reset
    task automatic idle_clocks(input int n);
        logic rb;
        repeat (n) bit_io(1'b1, rb);
    endtask
    // Start or repeated start; long high phase so the system side sees it
    task automatic start();
        if (scl) begin
            #(HALF) scl = 1'b0;
        end
        #4 sda_low = 1'b0;
        #(HALF) scl = 1'b1;
        #150 sda_low = 1'b1;
        #150 scl = 1'b0;
    endtask
    // Stop, then the clock stands still
    task automatic stop();
        #4 sda_low = 1'b1;
        #(HALF) scl = 1'b1;
        #150 sda_low = 1'b0;
        #300;
    endtask
    // Byte out, then the acknowledge slot with SDA released
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic rb;
        for (int i = 7; i >= 0; i--) bit_io(d[i], rb);
        bit_io(1'b1, ack);
    endtask
    // Byte in, acknowledge left to the caller
    task automatic recv_byte(output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
`include "i2cms_consts.svh"
module testbench;
    import i2cms_pkg::*;
    logic clk_sys, rst, low_vcc, scl, m_low, sda_i, sda_o, sda_oe;
    logic link_busy, access_inhibit;
    logic [9:0] mem_addr;
    logic [7:0] mem_rdata;
    i2cms_wr_s mem_wr;
    logic [7:0] mem [0:1023]; // Byte array behind the block
    int errors = 0;
    int n_checks = 0;
    // Wired-AND line with pull-up
    assign sda_i = !(sda_oe && !sda_o) && !m_low;
    assign mem_rdata = mem[mem_addr];
    // Array write while the strobe stands
    always @(posedge scl) begin
        if (mem_wr.we === 1'b1) begin
            mem[mem_wr.waddr] <= mem_wr.wdata;
        end
    end
    i2cms_top DUT (.CLK_SYS(clk_sys), .RST(rst), .LOW_VCC(low_vcc), .SCL(scl),
        .SDA_I(sda_i), .SDA_O(sda_o), .SDA_OE(sda_oe), .MEM_ADDR(mem_addr),
        .MEM_RDATA(mem_rdata), .MEM_WR(mem_wr), .LINK_BUSY(link_busy),
        .ACCESS_INHIBIT(access_inhibit));
    i2cms_master_model master (.scl(scl), .sda_low(m_low), .sda(sda_i));
    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Slave address byte
    function automatic logic [7:0] sa(input logic [1:0] pg, input logic rw, input logic sel);
        return {`I2CMS_TYPE_CODE, sel, pg, rw};
    endfunction
    // Byte to the device, acknowledge compared
    task automatic sendb(input logic [7:0] b, input logic exp_ack);
        logic a;
        master.send_byte(b, a);
        check(8'(a), 8'(exp_ack));
    endtask
    // Byte from the device
    task automatic readb(input logic [7:0] exp);
        logic [7:0] d;
        master.recv_byte(d);
        check(d, exp);
    endtask
    // Master acknowledge slot; a released device reads high
    task automatic ackb(input logic b);
        logic rb;
        master.bit_io(b, rb);
        check(8'(rb), 8'(b));
    endtask
    // Outputs quiet in reset, then release and power-up wait
    task automatic t_reset();
        @(negedge clk_sys);
        check(8'({access_inhibit, sda_oe, link_busy, mem_wr.we}), 8'h08);
        @(posedge clk_sys) rst <= 1'b0;
        repeat (`I2CMS_POWER_UP_READ_DELAY_US * 20) @(posedge clk_sys);
        check(8'(access_inhibit), 8'h00);
        master.idle_clocks(2);
        $display("test reset done");
    endtask
    // Unaligned write across a page boundary
    task automatic t_write();
        master.start();
        repeat (4) @(posedge clk_sys);
        check(8'(link_busy), 8'h01);
        sendb(sa(2'b10, 1'b0, 1'b0), 1'b0);
        sendb(8'hFE, 1'b0);
        sendb(8'hA1, 1'b0);
        sendb(8'hB2, 1'b0);
        sendb(8'h4D, 1'b0);
        master.stop();
        check(8'(link_busy), 8'h00);
        check(mem[10'h2FE], 8'hA1);
        check(mem[10'h2FF], 8'hB2);
        check(mem[10'h300], 8'h4D);
        $display("test write done");
    endtask
    // Random read straight after the write
    task automatic t_rand_read();
        master.start();
        sendb(sa(2'b10, 1'b0, 1'b0), 1'b0);
        sendb(8'hFF, 1'b0);
        master.start();
        sendb(sa(2'b10, 1'b1, 1'b0), 1'b0);
        readb(8'hB2);
        ackb(1'b0);
        readb(8'h4D);
        ackb(1'b1);
        master.stop();
        $display("test random read done");
    endtask
    // Current-address reads, every read ending, wrong type code
    task automatic t_cur_read();
        master.start();
        sendb(sa(2'b01, 1'b1, 1'b1), 1'b0);
        readb(8'h3D);
        master.stop();
        master.start();
        sendb(sa(2'b01, 1'b1, 1'b0), 1'b0);
        readb(8'h3E);
        master.start();
        sendb(8'h33, 1'b1);
        master.start();
        sendb(sa(2'b01, 1'b1, 1'b0), 1'b0);
        readb(8'h3F);
        ackb(1'b1);
        master.start();
        master.stop();
        $display("test current read done");
    endtask
    // Counter holds at the top location
    task automatic t_top();
        master.start();
        sendb(sa(2'b11, 1'b0, 1'b0), 1'b0);
        sendb(8'hFE, 1'b0);
        sendb(8'h11, 1'b0);
        sendb(8'h22, 1'b0);
        sendb(8'h33, 1'b0);
        master.stop();
        check(mem[10'h3FF], 8'h33);
        check(mem[10'h000], 8'h3C);
        master.start();
        sendb(sa(2'b11, 1'b1, 1'b0), 1'b0);
        readb(8'h33);
        ackb(1'b0);
        readb(8'h33);
        ackb(1'b1);
        master.stop();
        $display("test top address done");
    endtask
    // Aborted write, then low supply in mid-byte
    task automatic t_abort();
        logic rb;
        master.start();
        sendb(sa(2'b00, 1'b0, 1'b0), 1'b0);
        sendb(8'h10, 1'b0);
        repeat (6) master.bit_io(1'b0, rb);
        master.start();
        check(mem[10'h010], 8'h2C);
        sendb(sa(2'b00, 1'b0, 1'b0), 1'b0);
        sendb(8'h20, 1'b0);
        repeat (4) master.bit_io(1'b0, rb);
        @(posedge clk_sys) low_vcc <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(8'({access_inhibit, sda_oe}), 8'h02);
        repeat (4) master.bit_io(1'b0, rb);
        master.bit_io(1'b1, rb);
        check(8'(rb), 8'h01);
        check(mem[10'h020], 8'h1C);
        @(posedge clk_sys) low_vcc <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check(8'(access_inhibit), 8'h00);
        master.idle_clocks(2);
        master.start();
        sendb(sa(2'b00, 1'b0, 1'b0), 1'b0);
        sendb(8'h20, 1'b0);
        master.start();
        sendb(sa(2'b00, 1'b1, 1'b0), 1'b0);
        readb(8'h1C);
        ackb(1'b1);
        master.stop();
        $display("test abort done");
    endtask
    // Main sequence; SCL toggles during reset to flush the link side
    initial begin
        rst = 1'b1;
        low_vcc = 1'b0;
        for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'h3C;
        fork
            master.idle_clocks(3);
            repeat (5) @(posedge clk_sys);
        join
        t_reset();
        t_write();
        t_rand_read();
        t_cur_read();
        t_top();
        t_abort();
        finish_test();
    end
    // Hang guard, far beyond the expected run
    initial begin
        #500000;
        errors++;
        finish_test();
    end
endmodule
